//--- pam_map.sv
// Program/verify mode entry, serial pointer loading and address map decode
// How it works
// - Code memory split into protection blocks plus boot
// - 64K part: four blocks, boot up to 1FFF
// - 96K part: six blocks, boot default 07FF
// - Two-bit field picks 1, 2, 4K words
// - One-bit field picks 1K or 2K words
// - Smallest parts pick 256, 512, 1024 words
// - Two 8K blocks: boot through 0003FF
// - Single block ends 03FFF, boot to 07FF or 0FFF
// - Eight ID bytes readable despite protection
// - Configuration bytes readable despite protection
// - Identity bytes at top two addresses readable
// - Three pointer bytes form 22-bit address
// - Pointer bytes sit at FF8, FF7, FF6
// - Core command executes pointer-loading instructions
// - Program mode enables serial access
// - Unused pins released once mode entered
// - Command shifted least significant bit first
`timescale 1ns/1ps
`default_nettype none

module pam_map #(
  parameter pam_pkg::pam_variant_e VARIANT = pam_pkg::VAR_64K
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              serial_prog_clock_pin,
  input  wire logic              serial_prog_data_in,
  output logic                   serial_prog_data_out,
  output logic                   serial_prog_data_oe,
  input  wire logic              master_clear_vpp_pin_at_hv,
  input  wire logic [1:0]        boot_block_size_field,
  output logic                   prog_mode,
  output logic                   unused_io_hiz,
  output pam_pkg::pam_ptr_s      ptr_out,
  output pam_pkg::pam_loc_s      loc_out
);

  // ****************************************************************
  // Map helpers
  // ****************************************************************

  // Last boot address for the variant and its size field
  function automatic logic [21:0] boot_end(input logic [1:0] f);
    logic [21:0] e;
    e = pam_pkg::BOOT_1KW;
    unique case (VARIANT)
      pam_pkg::VAR_64K, pam_pkg::VAR_96K: begin
        if (f == pam_pkg::BBSZ_SMALL)    e = pam_pkg::BOOT_1KW;
        else if (f == pam_pkg::BBSZ_MID) e = pam_pkg::BOOT_2KW;
        else                             e = pam_pkg::BOOT_4KW;
      end
      pam_pkg::VAR_ONEBIT: begin
        e = f[0] ? pam_pkg::BOOT_2KW : pam_pkg::BOOT_1KW;
      end
      pam_pkg::VAR_SMALL: begin
        if (f == pam_pkg::BBSZ_SMALL)    e = pam_pkg::BOOT_256W;
        else if (f == pam_pkg::BBSZ_MID) e = pam_pkg::BOOT_512W;
        else                             e = pam_pkg::BOOT_1KW;
      end
      pam_pkg::VAR_TWO8K: begin
        e = pam_pkg::BOOT_512W;
      end
    endcase
    return e;
  endfunction : boot_end

  // Last code address for the variant
  function automatic logic [21:0] code_end();
    logic [21:0] e;
    e = pam_pkg::END_64K;
    unique case (VARIANT)
      pam_pkg::VAR_64K:    e = pam_pkg::END_64K;
      pam_pkg::VAR_96K:    e = pam_pkg::END_96K;
      pam_pkg::VAR_ONEBIT: e = pam_pkg::END_16K;
      pam_pkg::VAR_SMALL:  e = pam_pkg::END_SMALL;
      pam_pkg::VAR_TWO8K:  e = pam_pkg::END_16K;
    endcase
    return e;
  endfunction : code_end

  // Protection block size as a shift
  function automatic int block_shift();
    int s;
    s = pam_pkg::SHIFT_16KB;
    unique case (VARIANT)
      pam_pkg::VAR_64K, pam_pkg::VAR_96K, pam_pkg::VAR_ONEBIT:
        s = pam_pkg::SHIFT_16KB;
      pam_pkg::VAR_SMALL: s = pam_pkg::SHIFT_4KB;
      pam_pkg::VAR_TWO8K: s = pam_pkg::SHIFT_8KB;
    endcase
    return s;
  endfunction : block_shift

  // ****************************************************************
  // Pin synchronisers (system clock)
  // ****************************************************************
  logic [pam_pkg::SYNC_N-1:0] sync_in;
  logic [pam_pkg::SYNC_N-1:0] filt_reg;
  logic                       tog_link_reg;

  // Bit 3 pointer toggle, 2 high voltage, 1 clock pin, 0 data pin
  assign sync_in = {tog_link_reg, master_clear_vpp_pin_at_hv,
                    serial_prog_clock_pin, serial_prog_data_in};

  // Three stages; a level counts only when the last two agree
  genvar gi;
  generate
    for (gi = 0; gi < pam_pkg::SYNC_N; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= sync_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          filt_reg[gi] <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          filt_reg[gi] <= s3_reg;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Program/verify mode entry (system clock)
  // ****************************************************************
  logic hv_prev_reg;
  logic tog_prev_reg;
  logic prog_mode_reg;

  // Edge memories for high voltage and pointer toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hv_prev_reg  <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else begin
      hv_prev_reg  <= filt_reg[2];
      tog_prev_reg <= filt_reg[3];
    end
  end

  // Entry only on a high-voltage rise seen with clock and data low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_mode_reg <= 1'b0;
    end else if (!filt_reg[2]) begin
      prog_mode_reg <= 1'b0;
    end else if (!hv_prev_reg && !filt_reg[1] && !filt_reg[0]) begin
      prog_mode_reg <= 1'b1;
    end
  end

  assign prog_mode     = prog_mode_reg;
  assign unused_io_hiz = prog_mode_reg;

  // ****************************************************************
  // Serial link (programmer clock)
  // ****************************************************************
  // Held in reset outside program mode; the programmer keeps the clock
  // low across entry, so release never meets a link clock edge.
  logic            link_rst;
  pam_pkg::pam_link_e link_state_reg;
  logic [4:0]      bit_cnt_reg;
  logic [3:0]      cmd_reg;
  logic [15:0]     opnd_reg;
  logic [15:0]     opnd_full;
  logic [7:0]      wreg_reg;
  pam_pkg::pam_ptr_s ptr_link_reg;
  logic            last_opnd_bit;

  assign link_rst      = rst | ~prog_mode_reg;
  assign last_opnd_bit = (link_state_reg == pam_pkg::LS_OPND) &&
                         (bit_cnt_reg == 5'(pam_pkg::OPND_BITS - 1));
  assign opnd_full     = {serial_prog_data_in, opnd_reg[15:1]};

  // Framing: four command bits, then sixteen operand bits
  always_ff @(posedge serial_prog_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      link_state_reg <= pam_pkg::LS_CMD;
      bit_cnt_reg    <= 5'h00;
    end else begin
      unique case (link_state_reg)
        pam_pkg::LS_CMD: begin
          if (bit_cnt_reg == 5'(pam_pkg::CMD_BITS - 1)) begin
            link_state_reg <= pam_pkg::LS_OPND;
            bit_cnt_reg    <= 5'h00;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        pam_pkg::LS_OPND: begin
          if (last_opnd_bit) begin
            link_state_reg <= pam_pkg::LS_CMD;
            bit_cnt_reg    <= 5'h00;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // Shift registers fill from the top, so first bit lands at bit 0
  always_ff @(posedge serial_prog_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      cmd_reg  <= 4'h0;
      opnd_reg <= 16'h0000;
    end else if (link_state_reg == pam_pkg::LS_CMD) begin
      cmd_reg <= {serial_prog_data_in, cmd_reg[3:1]};
    end else begin
      opnd_reg <= opnd_full;
    end
  end

  // Core instruction: load literal, then move it to a pointer byte
  always_ff @(posedge serial_prog_clock_pin or posedge link_rst) begin
    if (link_rst) begin
      wreg_reg     <= 8'h00;
      ptr_link_reg <= '0;
      tog_link_reg <= 1'b0;
    end else if (last_opnd_bit && cmd_reg == pam_pkg::CMD_CORE) begin
      if (opnd_full[15:8] == pam_pkg::OP_LOAD_W) begin
        wreg_reg <= opnd_full[7:0];
      end else if (opnd_full[15:8] == pam_pkg::OP_STORE_W) begin
        // Access-bank form names only the low byte of the RAM address
        if (opnd_full[7:0] == pam_pkg::RAM_PTR_UPPER[7:0]) begin
          ptr_link_reg.upper <= wreg_reg[5:0];
          tog_link_reg       <= ~tog_link_reg;
        end else if (opnd_full[7:0] == pam_pkg::RAM_PTR_HIGH[7:0]) begin
          ptr_link_reg.high <= wreg_reg;
          tog_link_reg      <= ~tog_link_reg;
        end else if (opnd_full[7:0] == pam_pkg::RAM_PTR_LOW[7:0]) begin
          ptr_link_reg.low <= wreg_reg;
          tog_link_reg     <= ~tog_link_reg;
        end
      end
    end
  end

  // Reads are not served here, so the data pin is never driven
  assign serial_prog_data_out = 1'b0;
  assign serial_prog_data_oe  = 1'b0;

  // ****************************************************************
  // Pointer copy and region decode (system clock)
  // ****************************************************************
  // The pointer word stays still for many link clocks after its toggle,
  // so copying on the synchronised toggle edge is safe.
  pam_pkg::pam_ptr_s ptr_copy_reg;
  pam_pkg::pam_loc_s loc_reg;
  pam_pkg::pam_loc_s loc_next;
  logic [21:0]       addr;
  logic [21:0]       boot_last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_copy_reg <= '0;
    end else if (!prog_mode_reg) begin
      ptr_copy_reg <= '0; // Even toggle counts give no copy edge on exit
    end else if (filt_reg[3] != tog_prev_reg) begin
      ptr_copy_reg <= ptr_link_reg;
    end
  end

  assign addr      = ptr_copy_reg;
  assign boot_last = boot_end(boot_block_size_field);

  // Region, protection block and protection exemption of the pointer
  always_comb begin
    loc_next.region      = pam_pkg::RGN_NONE;
    loc_next.block       = 3'h0;
    loc_next.prot_exempt = 1'b0;
    if (addr <= boot_last) begin
      loc_next.region = pam_pkg::RGN_BOOT;
    end else if (addr <= code_end()) begin
      loc_next.region = pam_pkg::RGN_CODE;
      loc_next.block  = 3'(addr >> block_shift());
    end else if (addr >= pam_pkg::ID_FIRST && addr <= pam_pkg::ID_LAST) begin
      loc_next.region      = pam_pkg::RGN_ID;
      loc_next.prot_exempt = 1'b1;
    end else if (addr >= pam_pkg::CFG_FIRST && addr <= pam_pkg::CFG_LAST) begin
      loc_next.region      = pam_pkg::RGN_CFG;
      loc_next.prot_exempt = 1'b1;
    end else if (addr >= pam_pkg::DEVID_FIRST) begin
      loc_next.region      = pam_pkg::RGN_DEVID;
      loc_next.prot_exempt = 1'b1;
    end
  end

  // Registered so the outputs come from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loc_reg <= '{region: pam_pkg::RGN_BOOT, block: 3'h0, prot_exempt: 1'b0};
    end else begin
      loc_reg <= loc_next;
    end
  end

  assign ptr_out = ptr_copy_reg;
  assign loc_out = loc_reg;

endmodule : pam_map

`default_nettype wire

//--- pam_pkg.sv
// Constants and types for the program-mode address map block
package pam_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int          ADDR_W      = 22;
  localparam logic [21:0] ID_FIRST    = 22'h200000;
  localparam logic [21:0] ID_LAST     = 22'h200007;
  localparam logic [21:0] CFG_FIRST   = 22'h300000;
  localparam logic [21:0] CFG_LAST    = 22'h30000D;
  localparam logic [21:0] DEVID_FIRST = 22'h3FFFFE;
  localparam logic [21:0] DEVID_LAST  = 22'h3FFFFF;

  // Code ends and boot ends per variant
  localparam logic [21:0] END_64K     = 22'h00FFFF;
  localparam logic [21:0] END_96K     = 22'h017FFF;
  localparam logic [21:0] END_16K     = 22'h003FFF;
  localparam logic [21:0] END_SMALL   = 22'h001FFF;
  localparam logic [21:0] BOOT_256W   = 22'h0001FF;
  localparam logic [21:0] BOOT_512W   = 22'h0003FF;
  localparam logic [21:0] BOOT_1KW    = 22'h0007FF;
  localparam logic [21:0] BOOT_2KW    = 22'h000FFF;
  localparam logic [21:0] BOOT_4KW    = 22'h001FFF;
  localparam int          SHIFT_16KB  = 14;
  localparam int          SHIFT_8KB   = 13;
  localparam int          SHIFT_4KB   = 12;
  localparam logic [1:0]  BBSZ_SMALL  = 2'h0;
  localparam logic [1:0]  BBSZ_MID    = 2'h1;

  // ****************************************************************
  // Serial link framing and core instruction decode
  // ****************************************************************
  localparam int          CMD_BITS    = 4;
  localparam int          OPND_BITS   = 16;
  localparam logic [3:0]  CMD_CORE    = 4'h0;
  localparam logic [7:0]  OP_LOAD_W   = 8'h0E;
  localparam logic [7:0]  OP_STORE_W  = 8'h6E;
  localparam logic [11:0] RAM_PTR_UPPER = 12'hFF8;
  localparam logic [11:0] RAM_PTR_HIGH  = 12'hFF7;
  localparam logic [11:0] RAM_PTR_LOW   = 12'hFF6;
  localparam int          SYNC_N      = 4;

  typedef enum logic [4:0] {
    VAR_64K   = 5'h01,
    VAR_96K   = 5'h02,
    VAR_ONEBIT= 5'h04,
    VAR_SMALL = 5'h08,
    VAR_TWO8K = 5'h10
  } pam_variant_e;

  typedef enum logic [5:0] {
    RGN_BOOT  = 6'h01,
    RGN_CODE  = 6'h02,
    RGN_ID    = 6'h04,
    RGN_CFG   = 6'h08,
    RGN_DEVID = 6'h10,
    RGN_NONE  = 6'h20
  } pam_region_e;

  typedef enum logic [1:0] {
    LS_CMD  = 2'h1,
    LS_OPND = 2'h2
  } pam_link_e;

  typedef struct packed {
    logic [5:0] upper;
    logic [7:0] high;
    logic [7:0] low;
  } pam_ptr_s;

  typedef struct packed {
    pam_region_e region;
    logic [2:0]  block;
    logic        prot_exempt;
  } pam_loc_s;

endpackage : pam_pkg

//--- pam_map_checker.sv
// Port checks for the program-mode address map
`timescale 1ns/1ps
`default_nettype none

module pam_map_checker (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              serial_prog_clock_pin,
  input wire logic              serial_prog_data_in,
  input wire logic              master_clear_vpp_pin_at_hv,
  input wire logic [1:0]        boot_block_size_field,
  input wire logic              prog_mode,
  input wire logic              unused_io_hiz,
  input wire pam_pkg::pam_ptr_s ptr_out,
  input wire pam_pkg::pam_loc_s loc_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************
  // Decode reference
  // ****************************
  // Address behind loc_out; a field change gets time to settle before judging
  logic [21:0] a_q;
  logic [2:0]  sc;
  logic [21:0] be;
  logic [21:0] be_q;
  logic        q;
  logic        hv;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_q  <= '0;
      sc   <= '0;
      be_q <= pam_pkg::BOOT_1KW;
    end else begin
      a_q  <= ptr_out;
      be_q <= be; // Same field age as the decode inside loc_out
      sc  <= $changed(boot_block_size_field) ? 3'h0 : sc + {2'h0, sc != 3'h7};
    end
  end
  // Larger boot block shrinks block 0
  assign be = boot_block_size_field == 2'h0 ? pam_pkg::BOOT_1KW :
              boot_block_size_field == 2'h1 ? pam_pkg::BOOT_2KW : pam_pkg::BOOT_4KW;
  assign q  = !serial_prog_clock_pin && !serial_prog_data_in;
  assign hv = master_clear_vpp_pin_at_hv;
  // Mode entry, exit and pin release
  AST_HIZ: assert property (unused_io_hiz == prog_mode)
    else $error("pin release differs from mode");
  AST_ENTRY: assert property (($rose(hv) && q) ##1 (hv && q) [*6] |-> prog_mode)
    else $error("quiet entry not taken");
  AST_ENTRY_LOW: assert property ($rose(prog_mode) |-> $past(q, 4))
    else $error("entry with serial pins high");
  AST_EXIT: assert property ($fell(hv) ##1 !hv [*7] |-> !prog_mode)
    else $error("mode held after exit");
  AST_IDLE: assert property (!prog_mode [*8] |-> ptr_out == '0)
    else $error("pointer kept outside mode");
  // Region decode, one cycle behind the pointer
  AST_BOOT: assert property (sc == 3'h7 && a_q <= be_q |->
    loc_out.region == pam_pkg::RGN_BOOT && loc_out.block == 3'h0) else $error("boot decode");
  AST_CODE: assert property (sc == 3'h7 && a_q > be_q && a_q <= pam_pkg::END_64K |->
    loc_out.region == pam_pkg::RGN_CODE && loc_out.block == a_q[16:14]) else $error("code decode");
  AST_ID: assert property (a_q inside {[pam_pkg::ID_FIRST:pam_pkg::ID_LAST]} |->
    loc_out.region == pam_pkg::RGN_ID && loc_out.prot_exempt) else $error("id decode");
  AST_CFG: assert property (a_q inside {[pam_pkg::CFG_FIRST:pam_pkg::CFG_LAST]} |->
    loc_out.region == pam_pkg::RGN_CFG && loc_out.prot_exempt) else $error("config decode");
  AST_DEVID: assert property (a_q >= pam_pkg::DEVID_FIRST |->
    loc_out.region == pam_pkg::RGN_DEVID && loc_out.prot_exempt) else $error("identity decode");
  CV_ENTRY: cover property ($rose(prog_mode));
  CV_CODE: cover property (loc_out.region == pam_pkg::RGN_CODE);
  CV_ID: cover property (loc_out.region == pam_pkg::RGN_ID);
endmodule : pam_map_checker

bind pam_map pam_map_checker u_chk (.clk(clk), .rst(rst), .prog_mode(prog_mode),
  .serial_prog_clock_pin(serial_prog_clock_pin), .serial_prog_data_in(serial_prog_data_in),
  .master_clear_vpp_pin_at_hv(master_clear_vpp_pin_at_hv), .unused_io_hiz(unused_io_hiz),
  .boot_block_size_field(boot_block_size_field), .ptr_out(ptr_out), .loc_out(loc_out));
`default_nettype wire

//--- pam_prog_model.sv
// Behavioural programmer driving the serial pins
`timescale 1ns/1ps
`default_nettype none

module pam_prog_model (
  output var logic serial_prog_clock_pin,
  output var logic serial_prog_data_in,
  output var logic master_clear_vpp_pin_at_hv
);
  // Idle low; outside frames the serial clock moves only in an entry with bad set
  initial begin
    serial_prog_clock_pin = 1'b0;
    serial_prog_data_in = 1'b0;
    master_clear_vpp_pin_at_hv = 1'b0;
  end
  // Entry; bad raises the voltage with the clock high to provoke a refusal
  task automatic enter(input logic bad);
    serial_prog_clock_pin = bad;
    serial_prog_data_in = 1'b0;
    #100 master_clear_vpp_pin_at_hv = 1'b1;
    #400 serial_prog_clock_pin = 1'b0;
    #200;
  endtask : enter
  // Exit, then wait long enough for the mode to drop
  task automatic leave();
    #100 master_clear_vpp_pin_at_hv = 1'b0;
    #400;
  endtask : leave
  // Command then operand, each least significant bit first
  task automatic frame(input logic [3:0] cmd, input logic [15:0] opnd);
    logic [19:0] sh;
    sh = {opnd, cmd};
    #7;
    for (int i = 0; i < 20; i++) begin
      serial_prog_data_in = sh[i];
      #40 serial_prog_clock_pin = 1'b1;
      #40 serial_prog_clock_pin = 1'b0;
    end
    #211; // Gap lets the pointer copy land; odd length drifts the phase
  endtask : frame
  // W, then one pointer byte
  task automatic wr(input logic [7:0] val, input logic [7:0] dst);
    frame(pam_pkg::CMD_CORE, {pam_pkg::OP_LOAD_W, val});
    frame(pam_pkg::CMD_CORE, {pam_pkg::OP_STORE_W, dst});
  endtask : wr
  // Three pairs build the address
  task automatic load(input logic [21:0] a);
    wr({2'h0, a[21:16]}, pam_pkg::RAM_PTR_UPPER[7:0]);
    wr(a[15:8], pam_pkg::RAM_PTR_HIGH[7:0]);
    wr(a[7:0], pam_pkg::RAM_PTR_LOW[7:0]);
  endtask : load
endmodule : pam_prog_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the program-mode address map
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {
    logic [21:0] a;
    logic [1:0]  f;
    logic [5:0]  r;
    logic [2:0]  b;
  } pam_row_s;
  logic              clk;
  logic              rst;
  logic [1:0]        fld;
  logic              sclk;
  logic              sdat;
  logic              hv;
  logic              mode;
  logic              hiz;
  logic              sdo;
  logic              soe;
  pam_pkg::pam_ptr_s ptr;
  pam_pkg::pam_loc_s loc;
  int                fail_count = 0;
  int                checks = 0;
  int                cyc = 0;
  // Address, boot field, region, block
  pam_row_s          rows [12] = '{
    '{22'h0007FF, 2'h0, 6'h01, 3'h0}, '{22'h000800, 2'h0, 6'h02, 3'h0},
    '{22'h000800, 2'h1, 6'h01, 3'h0}, '{22'h001FFF, 2'h2, 6'h01, 3'h0},
    '{22'h002000, 2'h3, 6'h02, 3'h0}, '{22'h00FFFF, 2'h0, 6'h02, 3'h3},
    '{22'h010000, 2'h0, 6'h20, 3'h0}, '{22'h200007, 2'h0, 6'h04, 3'h0},
    '{22'h200008, 2'h0, 6'h20, 3'h0}, '{22'h30000D, 2'h0, 6'h08, 3'h0},
    '{22'h30000E, 2'h0, 6'h20, 3'h0}, '{22'h3FFFFE, 2'h0, 6'h10, 3'h0}};

  pam_map uut (.clk(clk), .rst(rst), .serial_prog_clock_pin(sclk),
    .serial_prog_data_in(sdat), .serial_prog_data_out(sdo), .serial_prog_data_oe(soe),
    .master_clear_vpp_pin_at_hv(hv), .boot_block_size_field(fld), .prog_mode(mode),
    .unused_io_hiz(hiz), .ptr_out(ptr), .loc_out(loc));
  pam_prog_model prog (.serial_prog_clock_pin(sclk), .serial_prog_data_in(sdat),
    .master_clear_vpp_pin_at_hv(hv));
  // System clock, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Any mismatch is counted and printed at once
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  // Reset, entry, table of map cases, then awkward cases
  initial begin
    rst = 1'b1;
    fld = 2'h0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    prog.enter(1'b0);
    chk(22'(mode), 22'h1);
    chk(22'(hiz), 22'h1);
    chk(22'({sdo, soe}), 22'h0);
    $display("entry done");
    foreach (rows[i]) begin
      @(posedge clk);
      #1 fld = rows[i].f;
      prog.load(rows[i].a);
      repeat (10) @(posedge clk);
      chk(ptr, rows[i].a);
      chk(22'(loc.region), 22'(rows[i].r));
      if (rows[i].r < 6'h04) chk(22'(loc.block), 22'(rows[i].b));
      if (rows[i].r inside {6'h04, 6'h08, 6'h10}) chk(22'(loc.prot_exempt), 22'h1);
      $display("row %0d done", i);
    end
    // Upper byte keeps six bits; a wrong command or target is ignored
    prog.wr(8'hE0, pam_pkg::RAM_PTR_UPPER[7:0]);
    repeat (10) @(posedge clk);
    chk(ptr, 22'h20FFFE);
    prog.frame(4'h1, 16'h6EF6);
    prog.frame(pam_pkg::CMD_CORE, 16'h6EF5);
    repeat (10) @(posedge clk);
    chk(ptr, 22'h20FFFE);
    $display("pointer byte test done");
    // Exit clears the pointer; entry with the clock high is refused
    prog.leave();
    chk(22'(mode), 22'h0);
    chk(ptr, 22'h0);
    prog.enter(1'b1);
    chk(22'(mode), 22'h0);
    prog.leave();
    $display("exit and refusal done");
    // Reset in mid-run drops the mode and the pointer
    prog.enter(1'b0);
    prog.load(22'h300005);
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 chk(22'(mode), 22'h0);
    chk(ptr, 22'h0);
    rst = 1'b0;
    // Re-entry after reset, then an even number of pointer writes before exit
    repeat (10) @(posedge clk);
    prog.wr(8'h12, pam_pkg::RAM_PTR_LOW[7:0]);
    prog.wr(8'h34, pam_pkg::RAM_PTR_HIGH[7:0]);
    repeat (10) @(posedge clk);
    chk(ptr, 22'h003412);
    prog.leave();
    chk(22'(mode), 22'h0);
    chk(ptr, 22'h0);
    $display("reset test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
